// *** bfhs_regs.vh ***
// constants for the buck fault and hiccup sequencer
`ifndef BFHS_REGS_VH
`define BFHS_REGS_VH
`define BFHS_OC_WINDOW      6'h20
`define BFHS_OC_LIMIT       3'h7
`define BFHS_HICCUP_CYCLES  3'h7
`define BFHS_ST_OFF         3'h0
`define BFHS_ST_START       3'h1
`define BFHS_ST_RUN         3'h2
`define BFHS_ST_HIC_CHG     3'h3
`define BFHS_ST_HIC_DIS     3'h4
`endif

// *** bfhs_sequencer.v ***
// fault supervision and start-up sequencer for a two-phase buck controller
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`include "bfhs_regs.vh"
module bfhs_sequencer #(
  parameter PHASES = 2
) (
  // clock, reset, enable
  input  wire              core_clk,
  input  wire              rst,
  input  wire              clk_en,
  // pwm timing
  input  wire              pwm_cycle_start,
  input  wire [PHASES-1:0] pwm_demand,
  // comparator flags
  input  wire [PHASES-1:0] overcurrent_flag,
  input  wire              overvoltage_flag,
  input  wire              undervoltage_flag,
  input  wire              pg_window_ok,
  input  wire              input_lockout_ok,
  input  wire              supply_lockout_ok,
  input  wire              por_good,
  input  wire              enable_in,
  input  wire              ss_at_ref,
  input  wire              ss_above_1v,
  input  wire              ss_discharged,
  // soft-start node control
  output reg               ss_charge_ff,
  output reg               ss_discharge_ff,
  // gate drives and status
  output reg  [PHASES-1:0] high_side_gate,
  output reg  [PHASES-1:0] low_side_gate,
  output reg               power_good_out,
  output reg               power_good_oe,
  output reg               hiccup_active_ff
);
  //////////////////////////////////////////////////////////////////////////
  // state codes and counts
  localparam [2:0] ST_OFF     = `BFHS_ST_OFF;
  localparam [2:0] ST_START   = `BFHS_ST_START;
  localparam [2:0] ST_RUN     = `BFHS_ST_RUN;
  localparam [2:0] ST_HIC_CHG = `BFHS_ST_HIC_CHG;
  localparam [2:0] ST_HIC_DIS = `BFHS_ST_HIC_DIS;
  localparam [5:0] WIN_LAST_W = `BFHS_OC_WINDOW - 6'h1;
  localparam [4:0] WIN_LAST   = WIN_LAST_W[4:0];
  localparam [2:0] OC_TRIP_AT = `BFHS_OC_LIMIT - 3'h1;
  localparam [2:0] HIC_ROUNDS = `BFHS_HICCUP_CYCLES;

  //////////////////////////////////////////////////////////////////////////
  // internal state
  reg  [2:0]        state_ff;
  reg  [2:0]        nxt_state;
  reg  [4:0]        win_cnt_ff;
  reg  [2:0]        oc_cnt_ff;
  reg  [2:0]        hic_cnt_ff;
  reg               oc_seen_ff;
  reg  [PHASES-1:0] cut_ff;
  reg               pg_ff;
  wire              allowed;
  wire              masked;
  wire              oc_this_cycle;
  wire              window_end;
  wire              oc_trip;
  wire              fault_hiccup;
  wire              switching;
  wire              ov_clamp;
  wire              in_hiccup_nxt;
  wire              charge_nxt;
  wire              discharge_nxt;
  wire              pg_nxt;

  //////////////////////////////////////////////////////////////////////////
  // qualified conditions
  assign allowed       = enable_in & supply_lockout_ok & input_lockout_ok & por_good;
  assign masked        = ~ss_above_1v;
  assign oc_this_cycle = oc_seen_ff | (|overcurrent_flag);
  assign window_end    = (win_cnt_ff == WIN_LAST);
  // the seventh counted cycle trips hiccup as the count reaches the limit
  assign oc_trip       = pwm_cycle_start & oc_this_cycle & (oc_cnt_ff == OC_TRIP_AT) & ~window_end;
  assign fault_hiccup  = ~masked & (oc_trip | undervoltage_flag);
  assign switching     = (state_ff == ST_START) || (state_ff == ST_RUN);
  assign ov_clamp      = overvoltage_flag & ~masked;
  assign in_hiccup_nxt = (nxt_state == ST_HIC_CHG) || (nxt_state == ST_HIC_DIS);
  assign charge_nxt    = (nxt_state == ST_START) || (nxt_state == ST_RUN) || (nxt_state == ST_HIC_CHG);
  assign discharge_nxt = (nxt_state == ST_OFF) || (nxt_state == ST_HIC_DIS);
  assign pg_nxt        = allowed && (state_ff == ST_RUN) && ss_above_1v && pg_window_ok &&
                         !overvoltage_flag && !undervoltage_flag;

  //////////////////////////////////////////////////////////////////////////
  // per-phase cycle cut and gate drive
  genvar g;
  generate
    for (g = 0; g < PHASES; g = g + 1) begin : g_phase
      // a flag seen anywhere in the cycle keeps the high side off until the next cycle start
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          cut_ff[g] <= 1'b0;
        end else if (clk_en) begin
          if (pwm_cycle_start) begin
            cut_ff[g] <= overcurrent_flag[g];
          end else if (overcurrent_flag[g]) begin
            cut_ff[g] <= 1'b1;
          end
        end
      end

      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          high_side_gate[g] <= 1'b0;
          low_side_gate[g]  <= 1'b0;
        end else if (clk_en) begin
          if (!allowed || !switching) begin
            high_side_gate[g] <= 1'b0;
            low_side_gate[g]  <= 1'b0;
          end else if (ov_clamp) begin
            high_side_gate[g] <= 1'b0;
            low_side_gate[g]  <= 1'b1;
          end else begin
            high_side_gate[g] <= pwm_demand[g] & ~cut_ff[g] & ~overcurrent_flag[g];
            low_side_gate[g]  <= ~pwm_demand[g] | cut_ff[g] | overcurrent_flag[g];
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // overcurrent window and event counter
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      win_cnt_ff <= 5'h0;
    end else if (clk_en) begin
      if (pwm_cycle_start) begin
        win_cnt_ff <= win_cnt_ff + 5'h1;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oc_seen_ff <= 1'b0;
    end else if (clk_en) begin
      if (pwm_cycle_start) begin
        oc_seen_ff <= 1'b0;
      end else if (|overcurrent_flag) begin
        oc_seen_ff <= 1'b1;
      end
    end
  end

  // the count saturates so a long masked overload cannot wrap it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oc_cnt_ff <= 3'h0;
    end else if (clk_en) begin
      if (pwm_cycle_start) begin
        if (window_end) begin
          oc_cnt_ff <= 3'h0;
        end else if (oc_this_cycle && (oc_cnt_ff != `BFHS_OC_LIMIT)) begin
          oc_cnt_ff <= oc_cnt_ff + 3'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // start-up and hiccup sequencer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (allowed) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        if (fault_hiccup) begin
          nxt_state = ST_HIC_DIS;
        end else if (ss_at_ref) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_hiccup) begin
          nxt_state = ST_HIC_DIS;
        end
      end
      ST_HIC_CHG: begin
        if (ss_above_1v) begin
          nxt_state = ST_HIC_DIS;
        end
      end
      ST_HIC_DIS: begin
        if (ss_discharged) begin
          if (hic_cnt_ff == HIC_ROUNDS) begin
            nxt_state = ST_START;
          end else begin
            nxt_state = ST_HIC_CHG;
          end
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (!allowed) begin
      nxt_state = ST_OFF;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_OFF;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // rounds count the discharge-to-charge turns of one hiccup
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hic_cnt_ff <= 3'h0;
    end else if (clk_en) begin
      if ((nxt_state == ST_HIC_DIS) && (state_ff != ST_HIC_CHG) && (state_ff != ST_HIC_DIS)) begin
        hic_cnt_ff <= 3'h0;
      end else if ((nxt_state == ST_HIC_CHG) && (state_ff == ST_HIC_DIS)) begin
        hic_cnt_ff <= hic_cnt_ff + 3'h1;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hiccup_active_ff <= 1'b0;
    end else if (clk_en) begin
      hiccup_active_ff <= in_hiccup_nxt;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ss_charge_ff <= 1'b0;
    end else if (clk_en) begin
      ss_charge_ff <= charge_nxt;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ss_discharge_ff <= 1'b1;
    end else if (clk_en) begin
      ss_discharge_ff <= discharge_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power good: open drain, enable high pulls the pin low
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pg_ff <= 1'b0;
    end else if (clk_en) begin
      pg_ff <= pg_nxt;
    end
  end

  always @* begin
    power_good_out = 1'b0;
    power_good_oe  = ~pg_ff;
  end

endmodule

// *** bfhs_sequencer_checker.sv ***
// port assertions for the fault and hiccup sequencer
`timescale 1ns/1ps
module bfhs_sequencer_checker #(parameter PHASES = 2) (
  input wire core_clk, input wire rst, input wire clk_en, input wire [PHASES-1:0] overcurrent_flag,
  input wire overvoltage_flag, input wire undervoltage_flag, input wire pg_window_ok, input wire input_lockout_ok,
  input wire supply_lockout_ok, input wire por_good, input wire enable_in, input wire ss_above_1v,
  input wire ss_charge_ff, input wire [PHASES-1:0] high_side_gate, input wire [PHASES-1:0] low_side_gate,
  input wire power_good_oe, input wire hiccup_active_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire run_ok = enable_in && por_good && input_lockout_ok && supply_lockout_ok;
  hic_gates_low_a: assert property (hiccup_active_ff && $past(hiccup_active_ff) |-> !high_side_gate && !low_side_gate)
    else $error("gate on in hiccup");
  oc_cut_a: assert property (clk_en && overcurrent_flag[0] |=> !high_side_gate[0]) else $error("oc kept hs");
  drive_off_a: assert property (clk_en && !run_ok ##1 clk_en && !run_ok |=> !high_side_gate && !low_side_gate)
    else $error("drive while off");
  ov_low_on_a: assert property ((clk_en && overvoltage_flag && ss_above_1v && run_ok && !undervoltage_flag
    && !overcurrent_flag && !hiccup_active_ff)[*2] |=> !high_side_gate && &low_side_gate) else $error("ov gates");
  pg_release_a: assert property (!power_good_oe |-> $past(run_ok && ss_above_1v && pg_window_ok))
    else $error("pg released early");
  mask_no_hic_a: assert property (clk_en && !ss_above_1v && !hiccup_active_ff |=> !hiccup_active_ff)
    else $error("hiccup while masked");
  no_start_a: assert property (clk_en && !ss_charge_ff && !hiccup_active_ff && !(enable_in && por_good) |=> !ss_charge_ff)
    else $error("start without enable");
  hic_exit_a: assert property ($fell(hiccup_active_ff) && $past(run_ok) |-> ss_charge_ff)
    else $error("no restart");
  uv_hic_a: assert property ((clk_en && undervoltage_flag && ss_above_1v && run_ok)[*2] |-> ##[0:1] hiccup_active_ff)
    else $error("uv no hiccup");
endmodule
bind bfhs_sequencer bfhs_sequencer_checker #(.PHASES(PHASES)) chk (.*);

// *** bfhs_stage_model.sv ***
// soft-start node model driven by the sequencer
`timescale 1ns/1ps
module bfhs_stage_model (
  input wire core_clk, input wire rst, input wire ss_charge_ff, input wire ss_discharge_ff, input wire clamp,
  output wire ss_at_ref, output wire ss_above_1v, output wire ss_discharged
);
  reg [3:0] lvl_ff;
  always @(posedge core_clk or posedge rst) begin
    if (rst) lvl_ff <= 4'h0;
    else if (ss_discharge_ff && lvl_ff != 4'h0) lvl_ff <= lvl_ff - 4'h1;
    else if (clamp && lvl_ff > 4'h8) lvl_ff <= lvl_ff - 4'h1;
    else if (ss_charge_ff && lvl_ff != 4'hc && !(clamp && lvl_ff == 4'h8)) lvl_ff <= lvl_ff + 4'h1;
  end
  assign ss_discharged = (lvl_ff == 4'h0);
  assign ss_at_ref = (lvl_ff >= 4'h7);
  assign ss_above_1v = (lvl_ff >= 4'ha);
endmodule

// *** bfhs_sequencer_bench.sv ***
// self-checking bench for the fault and hiccup sequencer
`timescale 1ns/1ps
module bfhs_sequencer_bench;
  reg core_clk = 1'b0, rst = 1'b1, pcs = 1'b0, ov = 1'b0, uv = 1'b0, pg_ok = 1'b1, in_ok = 1'b1, en = 1'b0;
  reg por = 1'b0, clamp = 1'b0, dis_q = 1'b0, ce = 1'b1;
  reg [1:0] dem = 2'h0, dem_q = 2'h0, oc = 2'h0, pc = 2'h0, hold_hs = 2'h0;
  wire at_ref, above, dchg, chg, dis, pg_out, pg_oe, hic;
  wire [1:0] hs, ls;
  integer num_errors = 0, cmp_count = 0, i = 0, rises = 0;
  always #5 core_clk = ~core_clk;
  bfhs_sequencer #(.PHASES(2)) dut (.core_clk(core_clk), .rst(rst), .clk_en(ce), .pwm_cycle_start(pcs),
    .pwm_demand(dem), .overcurrent_flag(oc), .overvoltage_flag(ov), .undervoltage_flag(uv), .pg_window_ok(pg_ok),
    .input_lockout_ok(in_ok), .supply_lockout_ok(1'b1), .por_good(por), .enable_in(en), .ss_at_ref(at_ref),
    .ss_above_1v(above), .ss_discharged(dchg), .ss_charge_ff(chg), .ss_discharge_ff(dis), .high_side_gate(hs),
    .low_side_gate(ls), .power_good_out(pg_out), .power_good_oe(pg_oe), .hiccup_active_ff(hic));
  bfhs_stage_model stage (.core_clk(core_clk), .rst(rst), .ss_charge_ff(chg), .ss_discharge_ff(dis),
    .clamp(clamp), .ss_at_ref(at_ref), .ss_above_1v(above), .ss_discharged(dchg));
  always @(posedge core_clk) begin
    dem_q = dem;
    if (dis === 1'b1 && dis_q === 1'b0) rises = rises + 1;
    dis_q = dis;
    #1 pc = pc + 2'h1;
    pcs = (pc == 2'h0);
    dem = 2'($urandom);
  end
  function [3:0] fault_gates(input ovf);
    fault_gates = ovf ? 4'h3 : 4'h0;
  endfunction
  task step(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input [8*10-1:0] name, input [3:0] exp, input [3:0] got);
    cmp_count = cmp_count + 1;
    if (exp !== got) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0s expected %h seen %h", name, exp, got);
    end
  endtask
  task wait_hic(input v, input integer n);
    for (i = 0; i < n && hic !== v; i = i + 1) step(1);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000 num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    i = $urandom(32'hf18480c7);
    step(10); rst = 1'b0; en = 1'b1;
    step(40); chk("no_start", 4'h0, {3'h0, chg});
    por = 1'b1;
    for (i = 0; i < 300 && pg_oe !== 1'b0; i = i + 1) step(1);
    chk("pg_release", 4'h0, {3'h0, pg_oe});
    chk("hs_demand", {2'h0, dem_q}, {2'h0, hs});
    pg_ok = 1'b0; step(2); chk("pg_window", 4'h1, {3'h0, pg_oe}); pg_ok = 1'b1;
    chk("pg_pin", 4'h0, {3'h0, pg_out});
    ov = 1'b1; step(3); chk("ov_gates", fault_gates(1'b1), {hs, ls});
    ov = 1'b0; step(3); chk("ov_resume", {2'h0, dem_q}, {hic, 1'b0, hs});
    rises = 0; oc = 2'h3; wait_hic(1'b1, 200); chk("oc_hiccup", 4'h1, {3'h0, hic});
    step(1); chk("hic_gates", fault_gates(1'b0), {hs, ls});
    rises = 0;
    wait_hic(1'b0, 2000); chk("hic_rounds", 4'h7, rises[3:0]);
    wait_hic(1'b1, 300); chk("re_enter", 4'h1, {3'h0, hic});
    oc = 2'h0; wait_hic(1'b0, 2000); step(100); chk("recovered", 4'h0, {3'h0, hic});
    ce = 1'b0;
    hold_hs = hs;
    step(6);
    chk("ce_freeze", {2'h0, hold_hs}, {2'h0, hs});
    ce = 1'b1;
    for (i = 0; i < 20; i = i + 1) begin
      oc = 2'h3;
      step(1);
      oc = 2'h0;
      step(23);
    end
    chk("oc_window", 4'h0, {3'h0, hic});
    uv = 1'b1; wait_hic(1'b1, 20); chk("uv_hiccup", 4'h1, {3'h0, hic}); uv = 1'b0;
    wait_hic(1'b0, 2000); en = 1'b0; step(3); chk("en_off", fault_gates(1'b0), {hs, ls});
    step(30); clamp = 1'b1; en = 1'b1; step(60); oc = 2'h3; uv = 1'b1; step(200);
    chk("mask_hic", 4'h1, {2'h0, hic, pg_oe});
    clamp = 1'b0; oc = 2'h0; uv = 1'b0;
    for (i = 0; i < 300 && pg_oe !== 1'b0; i = i + 1) step(1);
    in_ok = 1'b0; step(3); chk("lockout", fault_gates(1'b0), {hs, ls});
    wrap_up;
  end
endmodule
